/* File: dv/swdc_cmd_unit_assertions.sv */
module swdc_cmd_unit_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic debug_wire_in,
  input wire logic debug_wire_out,
  input wire logic debug_wire_oe,
  input wire logic halted_debug_mode,
  input wire logic [15:0] cpu_index_pair,
  input wire logic breakpoint_enable_bit,
  input wire logic force_tag_select_bit,
  input wire logic [15:0] breakpoint_match_register,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_access,
  input wire logic cpu_opfetch,
  input wire logic cpu_instr_boundary,
  input wire logic acc_load,
  input wire logic flags_load,
  input wire logic pc_load,
  input wire logic index_pair_load,
  input wire logic sp_load,
  input wire logic [15:0] load_data,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic resume,
  input wire logic ext_tag_en,
  input wire logic sync_active,
  input wire logic break_force,
  input wire logic opcode_tag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [8:0] low_run_reg;
  logic [8:0] low_run_next;
  logic any_upd;
  // length of the calibration low drive, shown at the pulse cycle
  assign low_run_next = (sync_active && debug_wire_oe && !debug_wire_out) ?
    low_run_reg + 9'h001 : 9'h000;
  always_ff @(posedge sys_clk) low_run_reg <= rst ? 9'h000 : low_run_next;
  assign any_upd = acc_load | flags_load | pc_load | index_pair_load | sp_load | mem_rd | mem_wr;

  a_tx_one_pulse: assert property (!sync_active && $rose(debug_wire_oe) && debug_wire_out
    |=> !debug_wire_oe) else $error("one bit drive held too long");
  a_tx_zero_shape: assert property (!sync_active && $rose(debug_wire_oe) && !debug_wire_out
    |-> (debug_wire_oe && !debug_wire_out)[*7] ##1 (debug_wire_oe && !debug_wire_out)[*6]
    ##1 (debug_wire_oe && debug_wire_out) ##1 !debug_wire_oe) else $error("zero bit shape");
  a_sync_low_len: assert property (sync_active && debug_wire_oe && debug_wire_out
    |-> low_run_reg == 9'h080) else $error("calibration low not 128 cycles");
  a_sync_release: assert property (sync_active && debug_wire_oe && debug_wire_out
    |=> !debug_wire_oe) else $error("calibration pulse not released");
  a_sync_gap: assert property (sync_active && $rose(debug_wire_oe)
    |-> $past(debug_wire_in, 16) && $past(debug_wire_in)) else $error("calibration gap short");
  a_halt_only: assert property (!halted_debug_mode && !$past(halted_debug_mode)
    |-> !any_upd) else $error("update while running");
  a_mem_next: assert property (mem_rd || mem_wr |-> index_pair_load && load_data == mem_addr
    && mem_addr == cpu_index_pair + 16'h0001) else $error("memory address not index plus one");
  a_resume_tag: assert property (resume |=> ext_tag_en) else $error("tagging not enabled");
  a_tag_fetch: assert property (breakpoint_enable_bit && !force_tag_select_bit && cpu_access
    && cpu_opfetch && cpu_addr == breakpoint_match_register ##1 breakpoint_enable_bit
    |-> opcode_tag) else $error("fetch at match not tagged");
  a_force_boundary: assert property (break_force
    |-> $past(cpu_instr_boundary) && $past(force_tag_select_bit)) else $error("bad forced break");
  a_bkpt_off: assert property (!breakpoint_enable_bit && !$past(breakpoint_enable_bit)
    |-> !break_force && !opcode_tag) else $error("break while disabled");
endmodule

bind swdc_cmd_unit swdc_cmd_unit_chk chk_u (.*);

/* File: dv/swdc_host_pod.sv */
module swdc_host_pod (
  input wire logic sys_clk,
  input wire logic debug_wire,
  output logic host_oe,
  output logic host_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int sync_low;
  int sync_gap;
  // released at start, pull-up holds the wire high
  initial begin
    host_oe = 1'b0;
    host_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one bit to the device, 20 cycles, opened by a fall
  task automatic put_bit(input logic b);
    host_oe = 1'b1;
    host_out = 1'b0;
    tick(b ? 4 : 15);
    host_out = 1'b1; // speedup before letting go
    tick(1);
    host_oe = 1'b0;
    tick(b ? 15 : 4);
  endtask
  // hold the fall until the device drives, so no second fall is seen
  task automatic get_bit(output logic b);
    host_oe = 1'b1;
    host_out = 1'b0;
    tick(6);
    host_oe = 1'b0;
    tick(4);
    b = debug_wire;
    tick(10);
  endtask
  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) put_bit(v[i]);
  endtask
  task automatic fetch(output logic [15:0] v, input int n);
    logic b;
    v = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      get_bit(b);
      v[i] = b;
    end
  endtask
  // long low, speedup, release, then time the answer
  task automatic sync_req();
    host_oe = 1'b1;
    host_out = 1'b0;
    tick(8192);
    host_out = 1'b1;
    tick(1);
    host_oe = 1'b0;
    sync_gap = 0;
    sync_low = 0;
    while (debug_wire === 1'b1 && sync_gap < 400) begin
      tick(1);
      sync_gap++;
    end
    while (debug_wire === 1'b0 && sync_low < 400) begin
      tick(1);
      sync_low++;
    end
  endtask
endmodule

/* File: dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk;
  logic rst;
  logic halted_debug_mode;
  logic [7:0] cpu_acc, cpu_condition_flags, debug_status_control_register, mem_rd_data;
  logic [15:0] cpu_pc, cpu_index_pair, cpu_sp, breakpoint_match_register, cpu_addr;
  logic breakpoint_enable_bit, force_tag_select_bit, cpu_access, cpu_opfetch;
  logic cpu_instr_boundary;
  wire debug_wire_out, debug_wire_oe, acc_load, flags_load, pc_load, index_pair_load, sp_load;
  wire mem_rd, mem_wr, resume, ext_tag_en, sync_active, break_force, opcode_tag;
  wire host_oe, host_out, debug_wire;
  wire [15:0] load_data, mem_addr;
  wire [7:0] mem_wdata;
  wire [6:0] upd;
  int upd_cnt [7];
  int resume_cnt, bf_cnt, tag_cnt, miscompares, n_tests;
  logic [15:0] last_load;

  // the device drive overrides the host; with neither driving, the pull-up wins
  assign debug_wire = debug_wire_oe ? debug_wire_out : (host_oe ? host_out : 1'b1);
  assign upd = {mem_wr, mem_rd, sp_load, index_pair_load, pc_load, flags_load, acc_load};

  swdc_cmd_unit dut_u (.sys_clk(sys_clk), .rst(rst), .debug_wire_in(debug_wire),
    .debug_wire_out(debug_wire_out), .debug_wire_oe(debug_wire_oe),
    .halted_debug_mode(halted_debug_mode), .cpu_acc(cpu_acc),
    .cpu_condition_flags(cpu_condition_flags), .cpu_pc(cpu_pc), .cpu_index_pair(cpu_index_pair),
    .cpu_sp(cpu_sp), .debug_status_control_register(debug_status_control_register),
    .mem_rd_data(mem_rd_data), .breakpoint_enable_bit(breakpoint_enable_bit),
    .force_tag_select_bit(force_tag_select_bit), .cpu_addr(cpu_addr),
    .breakpoint_match_register(breakpoint_match_register), .cpu_access(cpu_access),
    .cpu_opfetch(cpu_opfetch), .cpu_instr_boundary(cpu_instr_boundary), .acc_load(acc_load),
    .flags_load(flags_load), .pc_load(pc_load), .index_pair_load(index_pair_load),
    .sp_load(sp_load), .load_data(load_data), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .resume(resume), .ext_tag_en(ext_tag_en),
    .sync_active(sync_active), .break_force(break_force), .opcode_tag(opcode_tag));

  swdc_host_pod pod_u (.sys_clk(sys_clk), .debug_wire(debug_wire), .host_oe(host_oe),
    .host_out(host_out));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // pulse counts kept apart from the design
  always @(posedge sys_clk) begin
    for (int i = 0; i < 7; i++) begin
      if (upd[i] === 1'b1) upd_cnt[i]++;
    end
    if (|upd[4:0] === 1'b1) last_load = load_data;
    if (resume === 1'b1) resume_cnt++;
    if (break_force === 1'b1) bf_cnt++;
    if (opcode_tag === 1'b1) tag_cnt++;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic t_loads();
    logic [7:0] codes [5] = '{8'h48, 8'h49, 8'h4B, 8'h4C, 8'h4F};
    int c0;
    for (int i = 0; i < 5; i++) begin
      c0 = upd_cnt[i];
      pod_u.send({8'h00, codes[i]}, 8);
      pod_u.send(16'hA5C3 + 16'(i), i < 2 ? 8 : 16);
      pod_u.tick(24);
      check(16'(upd_cnt[i] - c0), 16'h0001);
      check(last_load, i < 2 ? 16'h00C3 + 16'(i) : 16'hA5C3 + 16'(i));
    end
    $display("test loads done");
  endtask

  task automatic t_reads();
    logic [7:0] codes [5] = '{8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6F};
    logic [15:0] exp [5];
    logic [15:0] v;
    for (int i = 0; i < 5; i++) begin
      // fresh acc, flags, pc and sp values each pass (index pair kept), so a stale capture shows
      {cpu_acc, cpu_condition_flags} = {cpu_acc + 8'h11, cpu_condition_flags - 8'h22};
      {cpu_pc, cpu_sp} = {cpu_pc + 16'h0103, cpu_sp - 16'h0210};
      exp = '{{8'h00, cpu_acc}, {8'h00, cpu_condition_flags}, cpu_pc, cpu_index_pair, cpu_sp};
      pod_u.send({8'h00, codes[i]}, 8);
      pod_u.tick(24);
      pod_u.fetch(v, i < 2 ? 8 : 16);
      check(v, exp[i]);
    end
    $display("test reads done");
  endtask

  task automatic t_mem();
    int r0;
    int w0;
    logic [15:0] v;
    r0 = upd_cnt[5];
    w0 = upd_cnt[6];
    pod_u.send(16'h0070, 8);
    pod_u.tick(24);
    pod_u.fetch(v, 8);
    check(v, {8'h00, mem_rd_data});
    check(last_load, 16'h1300);
    {mem_rd_data, debug_status_control_register} = 16'hA742;
    pod_u.send(16'h0071, 8);
    pod_u.tick(24);
    pod_u.fetch(v, 16);
    check(v, {debug_status_control_register, mem_rd_data});
    check(16'(upd_cnt[5] - r0), 16'h0002);
    pod_u.send(16'h5077, 16);
    pod_u.tick(24);
    check({8'h00, mem_wdata}, 16'h0077);
    pod_u.send(16'h51E4, 16);
    pod_u.tick(24);
    pod_u.fetch(v, 8);
    check(v, {8'h00, debug_status_control_register});
    check({8'h00, mem_wdata}, 16'h00E4);
    check(16'(upd_cnt[6] - w0), 16'h0002);
    check(mem_addr, 16'h1300);
    $display("test memory done");
  endtask

  task automatic t_refused();
    int a0;
    a0 = upd_cnt[0];
    halted_debug_mode = 1'b0;
    pod_u.send(16'h4811, 16);
    pod_u.tick(24);
    check(16'(upd_cnt[0] - a0), 16'h0000);
    halted_debug_mode = 1'b1;
    pod_u.send(16'h0048, 8);
    pod_u.send(16'h000A, 4);
    pod_u.tick(600);
    pod_u.send(16'h4966, 16);
    pod_u.tick(24);
    check(16'(upd_cnt[0] - a0), 16'h0000);
    check(last_load, 16'h0066);
    pod_u.send(16'h0018, 8);
    pod_u.tick(24);
    check(16'(resume_cnt), 16'h0001);
    check(16'(ext_tag_en), 16'h0001);
    $display("test refused and resume done");
  endtask

  task automatic t_sync();
    logic [15:0] v;
    pod_u.sync_req();
    check(16'(pod_u.sync_low), 16'h0080);
    check(16'(pod_u.sync_gap > 14 && pod_u.sync_gap < 25), 16'h0001);
    pod_u.tick(3);
    check(16'(sync_active), 16'h0000);
    pod_u.send(16'h0068, 8);
    pod_u.tick(24);
    pod_u.fetch(v, 8);
    check(v, {8'h00, cpu_acc});
    $display("test calibration done");
  endtask

  task automatic bus(input logic [15:0] a, input logic [2:0] k);
    cpu_addr = a;
    {cpu_access, cpu_opfetch, cpu_instr_boundary} = k;
    pod_u.tick(1);
    {cpu_access, cpu_opfetch, cpu_instr_boundary} = 3'h0;
  endtask

  task automatic t_bkpt();
    halted_debug_mode = 1'b0;
    breakpoint_match_register = 16'h2468;
    bus(16'h2468, 3'h5);
    force_tag_select_bit = 1'b0;
    bus(16'h2468, 3'h6);
    bus(16'h0000, 3'h1);
    pod_u.tick(3);
    check(16'(bf_cnt + tag_cnt), 16'h0000);
    breakpoint_enable_bit = 1'b1;
    force_tag_select_bit = 1'b1;
    bus(16'h2468, 3'h5);
    pod_u.tick(3);
    check(16'(bf_cnt), 16'h0000);
    bus(16'h0000, 3'h1);
    pod_u.tick(3);
    check(16'(bf_cnt), 16'h0001);
    force_tag_select_bit = 1'b0;
    bus(16'h2468, 3'h6);
    pod_u.tick(3);
    check(16'(tag_cnt), 16'h0001);
    check(16'(bf_cnt), 16'h0001);
    $display("test breakpoint done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    halted_debug_mode = 1'b1;
    {cpu_acc, cpu_condition_flags, debug_status_control_register} = 24'h3C9681;
    {cpu_pc, cpu_index_pair, cpu_sp} = 48'hC0DE_12FF_0A5F;
    mem_rd_data = 8'h5A;
    breakpoint_match_register = 16'h0000;
    cpu_addr = 16'h0000;
    {breakpoint_enable_bit, force_tag_select_bit} = 2'h1;
    {cpu_access, cpu_opfetch, cpu_instr_boundary} = 3'h0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check(16'({debug_wire_oe, resume, ext_tag_en, sync_active, break_force}), 16'h0000);
    pod_u.tick(5);
    t_loads();
    t_reads();
    t_mem();
    t_refused();
    t_sync();
    t_bkpt();
    stop_test();
  end
endmodule

/* File: pkg/swdc_consts.vh */
`ifndef SWDC_CONSTS_VH
`define SWDC_CONSTS_VH

// command codes (8-bit, host to device, msb first)
`define SWDC_RESUME_WITH_TAGGING_CMD 8'h18
`define SWDC_FETCH_ACC_CMD 8'h68
`define SWDC_FETCH_FLAGS_CMD 8'h69
`define SWDC_FETCH_PROGRAM_COUNTER_CMD 8'h6B
`define SWDC_FETCH_INDEX_PAIR_CMD 8'h6C
`define SWDC_FETCH_STACK_POINTER_CMD 8'h6F
`define SWDC_FETCH_INCREMENTED_BYTE_CMD 8'h70
`define SWDC_FETCH_INCREMENTED_BYTE_STATUS_CMD 8'h71
`define SWDC_LOAD_ACC_CMD 8'h48
`define SWDC_LOAD_FLAGS_CMD 8'h49
`define SWDC_LOAD_PROGRAM_COUNTER_CMD 8'h4B
`define SWDC_LOAD_INDEX_PAIR_CMD 8'h4C
`define SWDC_LOAD_STACK_POINTER_CMD 8'h4F
`define SWDC_STORE_INCREMENTED_BYTE_CMD 8'h50
`define SWDC_STORE_INCREMENTED_BYTE_STATUS_CMD 8'h51

// decode word field positions
`define SWDC_INFO_WD_LSB 0
`define SWDC_INFO_RD_LSB 2
`define SWDC_INFO_ACTIVE 4
`define SWDC_INFO_VALID 5

// bit timing, in debug clock cycles from the perceived falling edge
`define SWDC_BIT_LAST 5'h0F
`define SWDC_SAMPLE_AT 5'h0A
`define SWDC_TX0_LOW_CYC 5'h0D
`define SWDC_TX1_PULSE_AT 5'h07

// command delay step, abort timeout, calibration timing
`define SWDC_DELAY_CYC 8'h10
`define SWDC_TMO_CYC 10'h200
`define SWDC_SYNC_DET_CYC 8'h80
`define SWDC_SYNC_GAP_CYC 8'h10
`define SWDC_SYNC_LOW_CYC 8'h80

// field widths in bits
`define SWDC_BYTE_BITS 5'h08
`define SWDC_WORD_BITS 5'h10

`endif

/* File: src/swdc_bkpt.v */
`include "swdc_consts.vh"

module swdc_bkpt (
  input wire sys_clk,
  input wire rst,
  input wire breakpoint_enable_bit,
  input wire force_tag_select_bit,
  input wire [15:0] breakpoint_match_register,
  input wire [15:0] cpu_addr,
  input wire cpu_access,
  input wire cpu_opfetch,
  input wire cpu_instr_boundary,
  output reg break_force_reg,
  output reg opcode_tag_reg
);

  reg pend_reg;
  wire hit;

  assign hit = cpu_access & (cpu_addr == breakpoint_match_register);

  // forced hit waits for the next boundary; a hit on a boundary cycle waits for the next one
  always @(posedge sys_clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
      break_force_reg <= 1'b0;
      opcode_tag_reg <= 1'b0;
    end else if (!breakpoint_enable_bit) begin
      pend_reg <= 1'b0;
      break_force_reg <= 1'b0;
      opcode_tag_reg <= 1'b0;
    end else begin
      // set wins over the boundary clear
      pend_reg <= (pend_reg & ~cpu_instr_boundary) | (hit & force_tag_select_bit);
      break_force_reg <= pend_reg & cpu_instr_boundary & force_tag_select_bit;
      // tag travels with the opcode; the cpu halts only if it reaches the queue end
      opcode_tag_reg <= hit & cpu_opfetch & ~force_tag_select_bit;
    end
  end

endmodule

/* File: src/swdc_cmd_unit.v */
`include "swdc_consts.vh"

module swdc_cmd_unit (
  input wire sys_clk,
  input wire rst,
  input wire debug_wire_in,
  output reg debug_wire_out,
  output reg debug_wire_oe,
  input wire halted_debug_mode,
  input wire [7:0] cpu_acc,
  input wire [7:0] cpu_condition_flags,
  input wire [15:0] cpu_pc,
  input wire [15:0] cpu_index_pair,
  input wire [15:0] cpu_sp,
  input wire [7:0] debug_status_control_register,
  input wire [7:0] mem_rd_data,
  input wire breakpoint_enable_bit,
  input wire force_tag_select_bit,
  input wire [15:0] breakpoint_match_register,
  input wire [15:0] cpu_addr,
  input wire cpu_access,
  input wire cpu_opfetch,
  input wire cpu_instr_boundary,
  output reg acc_load,
  output reg flags_load,
  output reg pc_load,
  output reg index_pair_load,
  output reg sp_load,
  output reg [15:0] load_data,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_rd,
  output reg mem_wr,
  output reg resume,
  output reg ext_tag_en,
  output reg sync_active,
  output wire break_force,
  output wire opcode_tag
);

  localparam ST_CMD = 3'h0;
  localparam ST_WD = 3'h1;
  localparam ST_DLY = 3'h2;
  localparam ST_TX = 3'h3;
  localparam ST_SWH = 3'h4;
  localparam ST_SGAP = 3'h5;
  localparam ST_SLOW = 3'h6;
  localparam ST_SHI = 3'h7;

  // decode word: valid, halt-only, read bytes, write bytes
  function [5:0] swdc_info;
    input [7:0] c;
    begin
      case (c)
        `SWDC_RESUME_WITH_TAGGING_CMD: swdc_info = 6'h30;
        `SWDC_FETCH_ACC_CMD,
        `SWDC_FETCH_FLAGS_CMD,
        `SWDC_FETCH_INCREMENTED_BYTE_CMD: swdc_info = 6'h34;
        `SWDC_FETCH_PROGRAM_COUNTER_CMD,
        `SWDC_FETCH_INDEX_PAIR_CMD,
        `SWDC_FETCH_STACK_POINTER_CMD,
        `SWDC_FETCH_INCREMENTED_BYTE_STATUS_CMD: swdc_info = 6'h38;
        `SWDC_LOAD_ACC_CMD,
        `SWDC_LOAD_FLAGS_CMD,
        `SWDC_STORE_INCREMENTED_BYTE_CMD: swdc_info = 6'h31;
        `SWDC_LOAD_PROGRAM_COUNTER_CMD,
        `SWDC_LOAD_INDEX_PAIR_CMD,
        `SWDC_LOAD_STACK_POINTER_CMD: swdc_info = 6'h32;
        `SWDC_STORE_INCREMENTED_BYTE_STATUS_CMD: swdc_info = 6'h35;
        default: swdc_info = 6'h00;
      endcase
    end
  endfunction

  // byte count field to bit count
  function [4:0] swdc_bits;
    input [1:0] n;
    begin
      swdc_bits = (n == 2'h2) ? `SWDC_WORD_BITS : `SWDC_BYTE_BITS;
    end
  endfunction

  reg s1_reg, s2_reg, s3_reg, lvl_reg;
  reg [4:0] bt_reg;
  reg bt_act_reg;
  reg [2:0] state_reg, state_next;
  reg [7:0] cmd_reg, cmd_next;
  reg [15:0] shift_reg, shift_next;
  reg [4:0] bits_reg, bits_next;
  reg [7:0] dly_reg, dly_next;
  reg [7:0] lowc_reg;
  reg [9:0] tmo_reg;
  reg txbit_reg, txbit_next;
  reg acc_load_next, flags_load_next, pc_load_next, index_pair_load_next, sp_load_next;
  reg [15:0] load_data_next, mem_addr_next;
  reg [7:0] mem_wdata_next;
  reg mem_rd_next, mem_wr_next, resume_next, ext_tag_en_next;
  reg wire_out_next, wire_oe_next;
  reg [5:0] info;

  wire lvl_now;
  wire fall;
  wire in_sync;
  wire [15:0] idx_inc;

  // a level change counts only once the two later stages agree
  assign lvl_now = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
  assign in_sync = state_reg[2];
  assign fall = lvl_reg & ~lvl_now & ~in_sync;
  assign idx_inc = cpu_index_pair + 16'h0001;

  // wire synchroniser, bit timer, low and timeout counters
  always @(posedge sys_clk) begin
    if (rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      lvl_reg <= 1'b1;
      bt_reg <= 5'h00;
      bt_act_reg <= 1'b0;
      lowc_reg <= 8'h00;
      tmo_reg <= 10'h000;
    end else begin
      s1_reg <= debug_wire_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_now;
      if (fall) begin
        bt_reg <= 5'h00;
        bt_act_reg <= 1'b1;
      end else if (bt_act_reg) begin
        bt_reg <= bt_reg + 5'h01;
        bt_act_reg <= (bt_reg != `SWDC_BIT_LAST);
      end
      // saturating, so a wire held low forever is seen once
      if (lvl_reg)
        lowc_reg <= 8'h00;
      else if (lowc_reg != 8'hFF)
        lowc_reg <= lowc_reg + 8'h01;
      if (fall)
        tmo_reg <= 10'h000;
      else if (tmo_reg != `SWDC_TMO_CYC)
        tmo_reg <= tmo_reg + 10'h001;
    end
  end

  // command sequencer and wire drive
  always @* begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    shift_next = shift_reg;
    bits_next = bits_reg;
    dly_next = dly_reg;
    txbit_next = txbit_reg;
    acc_load_next = 1'b0;
    flags_load_next = 1'b0;
    pc_load_next = 1'b0;
    index_pair_load_next = 1'b0;
    sp_load_next = 1'b0;
    load_data_next = load_data;
    mem_addr_next = mem_addr;
    mem_wdata_next = mem_wdata;
    mem_rd_next = 1'b0;
    mem_wr_next = 1'b0;
    resume_next = 1'b0;
    ext_tag_en_next = ext_tag_en;
    wire_out_next = 1'b0;
    wire_oe_next = 1'b0;
    info = swdc_info(cmd_reg);
    case (state_reg)
      ST_CMD, ST_WD: begin
        if (bt_act_reg && bt_reg == `SWDC_SAMPLE_AT) begin
          shift_next = {shift_reg[14:0], lvl_reg};
          bits_next = bits_reg - 5'h01;
          if (bits_reg == 5'h01) begin
            if (state_reg == ST_CMD) begin
              cmd_next = {shift_reg[6:0], lvl_reg};
              info = swdc_info({shift_reg[6:0], lvl_reg});
              shift_next = 16'h0000;
              bits_next = `SWDC_BYTE_BITS;
              dly_next = 8'h00;
              if (!info[`SWDC_INFO_VALID])
                state_next = ST_CMD;
              else if (info[`SWDC_INFO_ACTIVE] && !halted_debug_mode)
                state_next = ST_CMD;
              else if (info[`SWDC_INFO_WD_LSB +: 2] != 2'h0) begin
                state_next = ST_WD;
                bits_next = swdc_bits(info[`SWDC_INFO_WD_LSB +: 2]);
              end else
                state_next = ST_DLY;
            end else begin
              state_next = ST_DLY;
              dly_next = 8'h00;
            end
          end
        end
      end
      ST_DLY: begin
        dly_next = dly_reg + 8'h01;
        if (dly_reg == 8'h00) begin
          // internal accesses start at once; results are taken at the delay end
          case (cmd_reg)
            `SWDC_RESUME_WITH_TAGGING_CMD: begin
              resume_next = 1'b1;
              ext_tag_en_next = 1'b1;
            end
            `SWDC_FETCH_INCREMENTED_BYTE_CMD,
            `SWDC_FETCH_INCREMENTED_BYTE_STATUS_CMD: begin
              index_pair_load_next = 1'b1;
              load_data_next = idx_inc;
              mem_addr_next = idx_inc;
              mem_rd_next = 1'b1;
            end
            `SWDC_LOAD_ACC_CMD: begin
              acc_load_next = 1'b1;
              load_data_next = {8'h00, shift_reg[7:0]};
            end
            `SWDC_LOAD_FLAGS_CMD: begin
              flags_load_next = 1'b1;
              load_data_next = {8'h00, shift_reg[7:0]};
            end
            `SWDC_LOAD_PROGRAM_COUNTER_CMD: begin
              pc_load_next = 1'b1;
              load_data_next = shift_reg;
            end
            `SWDC_LOAD_INDEX_PAIR_CMD: begin
              index_pair_load_next = 1'b1;
              load_data_next = shift_reg;
            end
            `SWDC_LOAD_STACK_POINTER_CMD: begin
              sp_load_next = 1'b1;
              load_data_next = shift_reg;
            end
            `SWDC_STORE_INCREMENTED_BYTE_CMD,
            `SWDC_STORE_INCREMENTED_BYTE_STATUS_CMD: begin
              index_pair_load_next = 1'b1;
              load_data_next = idx_inc;
              mem_addr_next = idx_inc;
              mem_wdata_next = shift_reg[7:0];
              mem_wr_next = 1'b1;
            end
            default: begin
              resume_next = 1'b0;
            end
          endcase
        end
        if (dly_reg == `SWDC_DELAY_CYC - 8'h01) begin
          state_next = (info[`SWDC_INFO_RD_LSB +: 2] != 2'h0) ? ST_TX : ST_CMD;
          bits_next = (info[`SWDC_INFO_RD_LSB +: 2] != 2'h0) ?
                      swdc_bits(info[`SWDC_INFO_RD_LSB +: 2]) : `SWDC_BYTE_BITS;
          case (cmd_reg)
            `SWDC_FETCH_ACC_CMD: shift_next = {cpu_acc, 8'h00};
            `SWDC_FETCH_FLAGS_CMD: shift_next = {cpu_condition_flags, 8'h00};
            `SWDC_FETCH_PROGRAM_COUNTER_CMD: shift_next = cpu_pc;
            `SWDC_FETCH_INDEX_PAIR_CMD: shift_next = cpu_index_pair;
            `SWDC_FETCH_STACK_POINTER_CMD: shift_next = cpu_sp;
            `SWDC_FETCH_INCREMENTED_BYTE_CMD: shift_next = {mem_rd_data, 8'h00};
            `SWDC_FETCH_INCREMENTED_BYTE_STATUS_CMD:
              shift_next = {debug_status_control_register, mem_rd_data};
            `SWDC_STORE_INCREMENTED_BYTE_STATUS_CMD:
              shift_next = {debug_status_control_register, 8'h00};
            default: shift_next = 16'h0000;
          endcase
        end
      end
      ST_TX: begin
        // the host opens every bit; the device only holds or speeds up the level
        if (fall && bits_reg != 5'h00) begin
          txbit_next = shift_reg[15];
          shift_next = {shift_reg[14:0], 1'b0};
          bits_next = bits_reg - 5'h01;
        end else if (bits_reg == 5'h00 && bt_act_reg && bt_reg == `SWDC_BIT_LAST) begin
          state_next = ST_CMD;
          bits_next = `SWDC_BYTE_BITS;
        end
        if (bt_act_reg && !txbit_reg && bt_reg < `SWDC_TX0_LOW_CYC) begin
          wire_oe_next = 1'b1;
        end else if (bt_act_reg && !txbit_reg && bt_reg == `SWDC_TX0_LOW_CYC) begin
          wire_oe_next = 1'b1;
          wire_out_next = 1'b1;
        end else if (bt_act_reg && txbit_reg && bt_reg == `SWDC_TX1_PULSE_AT) begin
          wire_oe_next = 1'b1;
          wire_out_next = 1'b1;
        end
      end
      ST_SWH: begin
        dly_next = 8'h00;
        if (lvl_reg)
          state_next = ST_SGAP;
      end
      ST_SGAP: begin
        dly_next = dly_reg + 8'h01;
        if (dly_reg == `SWDC_SYNC_GAP_CYC - 8'h01) begin
          state_next = ST_SLOW;
          dly_next = 8'h00;
        end
      end
      ST_SLOW: begin
        dly_next = dly_reg + 8'h01;
        wire_oe_next = 1'b1;
        if (dly_reg == `SWDC_SYNC_LOW_CYC - 8'h01)
          state_next = ST_SHI;
      end
      ST_SHI: begin
        wire_oe_next = 1'b1;
        wire_out_next = 1'b1;
        state_next = ST_CMD;
        bits_next = `SWDC_BYTE_BITS;
      end
      default: begin
        state_next = ST_CMD;
        bits_next = `SWDC_BYTE_BITS;
      end
    endcase
    // abort leaves processor and memory alone: nothing is issued on this path
    if (!in_sync && tmo_reg == `SWDC_TMO_CYC) begin
      state_next = ST_CMD;
      bits_next = `SWDC_BYTE_BITS;
      wire_oe_next = 1'b0;
      acc_load_next = 1'b0;
      flags_load_next = 1'b0;
      pc_load_next = 1'b0;
      index_pair_load_next = 1'b0;
      sp_load_next = 1'b0;
      mem_rd_next = 1'b0;
      mem_wr_next = 1'b0;
      resume_next = 1'b0;
    end
    // own transmitted zeros stay far below the detect threshold; the level test
    // keeps our own 128-cycle answer from re-arming detection as it ends
    if (!in_sync && !lvl_reg && lowc_reg == `SWDC_SYNC_DET_CYC) begin
      state_next = ST_SWH;
      wire_oe_next = 1'b0;
    end
  end

  // registered state and outputs
  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_CMD;
      cmd_reg <= 8'h00;
      shift_reg <= 16'h0000;
      bits_reg <= `SWDC_BYTE_BITS;
      dly_reg <= 8'h00;
      txbit_reg <= 1'b1;
      debug_wire_out <= 1'b0;
      debug_wire_oe <= 1'b0;
      acc_load <= 1'b0;
      flags_load <= 1'b0;
      pc_load <= 1'b0;
      index_pair_load <= 1'b0;
      sp_load <= 1'b0;
      load_data <= 16'h0000;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      resume <= 1'b0;
      ext_tag_en <= 1'b0;
      sync_active <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      shift_reg <= shift_next;
      bits_reg <= bits_next;
      dly_reg <= dly_next;
      txbit_reg <= txbit_next;
      debug_wire_out <= wire_out_next;
      debug_wire_oe <= wire_oe_next;
      acc_load <= acc_load_next;
      flags_load <= flags_load_next;
      pc_load <= pc_load_next;
      index_pair_load <= index_pair_load_next;
      sp_load <= sp_load_next;
      load_data <= load_data_next;
      mem_addr <= mem_addr_next;
      mem_wdata <= mem_wdata_next;
      mem_rd <= mem_rd_next;
      mem_wr <= mem_wr_next;
      resume <= resume_next;
      ext_tag_en <= ext_tag_en_next;
      sync_active <= state_next[2];
    end
  end

  // breakpoint outputs are flip-flops inside the comparator
  swdc_bkpt u_bkpt (
    .sys_clk(sys_clk),
    .rst(rst),
    .breakpoint_enable_bit(breakpoint_enable_bit),
    .force_tag_select_bit(force_tag_select_bit),
    .breakpoint_match_register(breakpoint_match_register),
    .cpu_addr(cpu_addr),
    .cpu_access(cpu_access),
    .cpu_opfetch(cpu_opfetch),
    .cpu_instr_boundary(cpu_instr_boundary),
    .break_force_reg(break_force),
    .opcode_tag_reg(opcode_tag)
  );

endmodule
